// File: fwuc_pkg.sv
// Constants and types shared by the flash write unlock control block
package fwuc_pkg;
   // Register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_RST_CLR = 8'h40;
   localparam logic [7:0] IDX_CTRL = 8'h41;
   localparam logic [7:0] IDX_FARL = 8'h42;
   localparam logic [7:0] IDX_FARH = 8'h4A;
   localparam logic [7:0] IDX_FDL0 = 8'h43;
   localparam logic [7:0] IDX_FDH0 = 8'h4B;
   localparam int NUM_FD = 4;

   // Reset and clear register field positions
   localparam int RSTCLR_BUFCLR_POS = 0;
   localparam int RSTCLR_SWRST_POS = 4;
   localparam logic [7:0] RSTCLR_RST = 8'h00;

   // Control register layout
   typedef struct packed {
      logic wen_ctl;
      logic [2:0] op_mode;
      logic mode_chg;
      logic fwt;
      logic frden;
      logic frd;
   } fwuc_ctrl_s;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // Operating mode codes
   localparam logic [2:0] MODE_WRITE = 3'h0;
   localparam logic [2:0] MODE_ERASE = 3'h1;
   localparam logic [2:0] MODE_READ = 3'h3;
   localparam logic [2:0] MODE_WEN = 3'h6;

   // Unlock key, in order data one low/high to three low/high
   localparam logic [7:0] KEY_B0 = 8'h00;
   localparam logic [7:0] KEY_B1 = 8'h04;
   localparam logic [7:0] KEY_B2 = 8'h0D;
   localparam logic [7:0] KEY_B3 = 8'h09;
   localparam logic [7:0] KEY_B4 = 8'hC3;
   localparam logic [7:0] KEY_B5 = 8'h40;

   // Unlock window timing
   localparam int CLK_MHZ = 125;
   localparam int TICK_NS = 1000;
   localparam int CLK_NS = 8;
   localparam int CYC_PER_TICK = TICK_NS / CLK_NS;
   localparam int UNLOCK_US = 1000;
   localparam int UNLOCK_TICKS = UNLOCK_US * 1000 / TICK_NS;

   // Write buffer geometry
   localparam int WB_AW = 5;
   localparam int WB_DW = 16;
   localparam int WB_DEPTH = 32;

   // Serial programming word length
   localparam int SER_BITS = 16;

   // Unlock sequencer states
   typedef enum logic [1:0] {
      UL_IDLE,
      UL_ARMED,
      UL_CHECK
   } fwuc_ul_e;
endpackage

// File: fwuc_wbuf.sv
// Flash write buffer memory with registered read data
`timescale 1ns/1ns
module fwuc_wbuf (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [fwuc_pkg::WB_AW-1:0] waddr,
   input wire logic [fwuc_pkg::WB_DW-1:0] wdata,
   // Read port
   input wire logic re,
   input wire logic [fwuc_pkg::WB_AW-1:0] raddr,
   output logic [fwuc_pkg::WB_DW-1:0] rdata
);
   logic [fwuc_pkg::WB_DW-1:0] mem [fwuc_pkg::WB_DEPTH];

   // No reset on the array; the clear walker zeroes it when asked
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Read data held in a register
   always_ff @(posedge clk) begin
      if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule

// File: fwuc_top.sv
// Flash write unlock control with AHB-Lite register slave
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
// What this block does
// - Unused reset and clear register bits 7..5 and 3..1 read zero.
// - Writing one to buffer clear bit starts clearing; zero starts nothing.
// - Only software sets buffer clear bit; hardware clears it when done.
// - Mode change in mode 110 starts a 1ms window; key must arrive before expiry.
// - Key bytes 00 04 0D 09 C3 40 compared against data registers.
// - Timeout or wrong key leaves write enable off; retry whole sequence.
// - Every attempt ends with the mode change bit cleared by hardware.
// - With write enable on, mode 000 write via control register works; mode 001 erase does nothing.
// - Clearing control bit relocks writing; no timed sequence needed.
// - Serial programming uses one two-way data pin and external clock.
// - Control bit clears write enable, one has no effect, reads state.
// - Mode 000 write, 001 erase, 011 read, 110 write enable control.
module fwuc_top #(
   parameter int UNLOCK_TICKS = fwuc_pkg::UNLOCK_TICKS
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Status
   output logic flash_write_enable,
   output logic unlock_busy,
   // Serial programming pins
   input wire logic programming_clock_pin,
   input wire logic programming_data_pin_i,
   output logic programming_data_pin_o,
   output logic programming_data_pin_oe,
   // Serial programming user side
   input wire logic ser_drive,
   input wire logic [fwuc_pkg::SER_BITS-1:0] ser_tx_word,
   output logic [fwuc_pkg::SER_BITS-1:0] ser_rx_word,
   output logic ser_rx_valid
);
   localparam logic [15:0] TICKS_LAST = 16'(UNLOCK_TICKS - 1);
   localparam logic [6:0] PRE_LAST = 7'(fwuc_pkg::CYC_PER_TICK - 1);

   // Bus address phase capture
   logic ap_valid_ff;
   logic ap_write_ff;
   logic [7:0] ap_idx_ff;
   logic ap_hit_ff;
   // Registers
   logic [7:0] far_l_ff;
   logic [7:0] far_h_ff;
   logic [7:0] fdl_ff [fwuc_pkg::NUM_FD];
   logic [7:0] fdh_ff [fwuc_pkg::NUM_FD];
   fwuc_pkg::fwuc_ctrl_s ctrl_ff;
   logic swrst_ff;
   logic bufclr_ff;
   logic wen_ff;
   // Unlock sequencer
   fwuc_pkg::fwuc_ul_e ul_ff;
   logic [6:0] pre_ff;
   logic [15:0] win_ff;
   // Buffer clear walker and read pipe
   logic [fwuc_pkg::WB_AW-1:0] clr_addr_ff;
   logic rd_pend_ff;
   logic [fwuc_pkg::WB_DW-1:0] wb_rdata;
   // Serial programming
   logic [1:0] pck_sync_ff;
   logic [1:0] pda_sync_ff;
   logic pck_old_ff;
   logic [3:0] pbit_ff;
   logic [fwuc_pkg::SER_BITS-1:0] prx_ff;
   logic [fwuc_pkg::SER_BITS-1:0] ptx_ff;
   logic prx_valid_ff;

   // Bus decode
   wire ap_take = hsel && htrans[1] && hready;
   wire ap_hit = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
   wire wr_en = ap_valid_ff && ap_write_ff && ap_hit_ff;
   wire [7:0] wd = hwdata[7:0];
   wire wr_rstclr = wr_en && (ap_idx_ff == fwuc_pkg::IDX_RST_CLR);
   wire wr_ctrl = wr_en && (ap_idx_ff == fwuc_pkg::IDX_CTRL);
   wire wr_farl = wr_en && (ap_idx_ff == fwuc_pkg::IDX_FARL);
   wire wr_farh = wr_en && (ap_idx_ff == fwuc_pkg::IDX_FARH);
   wire wr_fdh3 = wr_en && (ap_idx_ff == fwuc_pkg::IDX_FDH0 + 8'h03);

   // Mode decode
   wire mode_wr = ctrl_ff.op_mode == fwuc_pkg::MODE_WRITE;
   wire mode_er = ctrl_ff.op_mode == fwuc_pkg::MODE_ERASE;
   wire mode_rd = ctrl_ff.op_mode == fwuc_pkg::MODE_READ;
   wire mode_wen = ctrl_ff.op_mode == fwuc_pkg::MODE_WEN;

   // Window timing: microsecond tick, then window counter
   wire tick = pre_ff == PRE_LAST;
   wire win_over = tick && (win_ff == TICKS_LAST);
   wire armed = ul_ff == fwuc_pkg::UL_ARMED;

   // Key comparison over the three data register pairs
   wire key_ok = (fdl_ff[1] == fwuc_pkg::KEY_B0) &&
                 (fdh_ff[1] == fwuc_pkg::KEY_B1) &&
                 (fdl_ff[2] == fwuc_pkg::KEY_B2) &&
                 (fdh_ff[2] == fwuc_pkg::KEY_B3) &&
                 (fdl_ff[3] == fwuc_pkg::KEY_B4) &&
                 (fdh_ff[3] == fwuc_pkg::KEY_B5);

   // Buffer operations
   wire clr_busy = bufclr_ff;
   wire clr_done = bufclr_ff && (clr_addr_ff == 5'h1F);
   wire fwt_go = ctrl_ff.fwt && !rd_pend_ff;
   wire do_write = fwt_go && wen_ff && mode_wr && !clr_busy;
   wire do_read = ctrl_ff.frd && ctrl_ff.frden && mode_rd && !rd_pend_ff;
   wire wb_we = clr_busy || do_write;
   wire [fwuc_pkg::WB_AW-1:0] far_a = far_l_ff[fwuc_pkg::WB_AW-1:0];
   wire [fwuc_pkg::WB_AW-1:0] wb_waddr = clr_busy ? clr_addr_ff : far_a;
   wire [fwuc_pkg::WB_DW-1:0] wb_wdata =
      clr_busy ? 16'h0000 : {fdh_ff[0], fdl_ff[0]};

   // Read mux; reserved reset and clear bits stay zero
   wire [7:0] rstclr_rd = {3'b000, swrst_ff, 3'b000, bufclr_ff};
   wire [7:0] ctrl_rd = {wen_ff, ctrl_ff[6:0]};
   wire [7:0] fdl_idx = ap_idx_ff - fwuc_pkg::IDX_FDL0;
   wire [7:0] fdh_idx = ap_idx_ff - fwuc_pkg::IDX_FDH0;
   wire is_fdl = fdl_idx < 8'(fwuc_pkg::NUM_FD);
   wire is_fdh = fdh_idx < 8'(fwuc_pkg::NUM_FD);
   wire [7:0] rd_byte =
      !ap_hit_ff ? 8'h00 :
      (ap_idx_ff == fwuc_pkg::IDX_RST_CLR) ? rstclr_rd :
      (ap_idx_ff == fwuc_pkg::IDX_CTRL) ? ctrl_rd :
      (ap_idx_ff == fwuc_pkg::IDX_FARL) ? far_l_ff :
      (ap_idx_ff == fwuc_pkg::IDX_FARH) ? far_h_ff :
      is_fdl ? fdl_ff[fdl_idx[1:0]] :
      is_fdh ? fdh_ff[fdh_idx[1:0]] : 8'h00;

   // Zero wait states, always OKAY; unmapped reads give zero
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = {24'h00_0000, rd_byte};
   assign flash_write_enable = wen_ff;
   assign unlock_busy = armed;

   // Address phase register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_ff <= 1'b0;
         ap_write_ff <= 1'b0;
         ap_idx_ff <= 8'h00;
         ap_hit_ff <= 1'b0;
      end else if (hready) begin
         ap_valid_ff <= ap_take;
         ap_write_ff <= hwrite;
         ap_idx_ff <= haddr[9:2];
         ap_hit_ff <= ap_hit;
      end
   end

   // Address registers; high byte keeps only bits 5..0, 7..6 read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         far_l_ff <= 8'h00;
         far_h_ff <= 8'h00;
      end else begin
         if (wr_farl) far_l_ff <= wd;
         if (wr_farh) far_h_ff <= {2'b00, wd[5:0]};
      end
   end

   // Data registers; a buffer read lands in pair zero
   generate
      for (genvar i = 0; i < fwuc_pkg::NUM_FD; i++) begin : g_fd
         wire wl = wr_en && (ap_idx_ff == fwuc_pkg::IDX_FDL0 + 8'(i));
         wire wh = wr_en && (ap_idx_ff == fwuc_pkg::IDX_FDH0 + 8'(i));
         wire ld = rd_pend_ff && (i == 0);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               fdl_ff[i] <= 8'h00;
               fdh_ff[i] <= 8'h00;
            end else if (ld) begin
               fdl_ff[i] <= wb_rdata[7:0];
               fdh_ff[i] <= wb_rdata[15:8];
            end else begin
               if (wl) fdl_ff[i] <= wd;
               if (wh) fdh_ff[i] <= wd;
            end
         end
      end
   endgenerate

   // Reset and clear register; a new set wins over completion
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         swrst_ff <= fwuc_pkg::RSTCLR_RST[fwuc_pkg::RSTCLR_SWRST_POS];
         bufclr_ff <= fwuc_pkg::RSTCLR_RST[fwuc_pkg::RSTCLR_BUFCLR_POS];
      end else begin
         if (wr_rstclr) swrst_ff <= wd[fwuc_pkg::RSTCLR_SWRST_POS];
         if (wr_rstclr && wd[fwuc_pkg::RSTCLR_BUFCLR_POS]) begin
            bufclr_ff <= 1'b1;
         end else if (clr_done) begin
            bufclr_ff <= 1'b0;
         end
      end
   end

   // Clear walker steps one buffer entry per cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clr_addr_ff <= 5'h00;
      end else if (clr_busy) begin
         clr_addr_ff <= clr_addr_ff + 5'h01;
      end else begin
         clr_addr_ff <= 5'h00;
      end
   end

   // Control register; hardware owns the self-clearing bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= fwuc_pkg::CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff.op_mode <= wd[6:4];
            ctrl_ff.frden <= wd[1];
         end
         // Mode change bit: set by software only outside an attempt
         if (wr_ctrl && wd[3] && !armed) begin
            ctrl_ff.mode_chg <= 1'b1;
         end else if (ctrl_ff.mode_chg && !mode_wen && !armed) begin
            ctrl_ff.mode_chg <= 1'b0;
         end else if (win_over && armed) begin
            ctrl_ff.mode_chg <= 1'b0;
         end else if (ul_ff == fwuc_pkg::UL_CHECK) begin
            ctrl_ff.mode_chg <= 1'b0;
         end
         // Write cycle takes one clock, set wins over completion
         if (wr_ctrl && wd[2]) begin
            ctrl_ff.fwt <= 1'b1;
         end else if (fwt_go && !clr_busy) begin
            ctrl_ff.fwt <= 1'b0;
         end
         // Read cycle ends when the data lands in pair zero
         if (wr_ctrl && wd[0]) begin
            ctrl_ff.frd <= 1'b1;
         end else if (rd_pend_ff || (ctrl_ff.frd && !ctrl_ff.frden)) begin
            ctrl_ff.frd <= 1'b0;
         end
         ctrl_ff.wen_ctl <= 1'b0;
      end
   end

   // Read pipe: one cycle for the registered buffer output
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_ff <= 1'b0;
      end else begin
         rd_pend_ff <= do_read;
      end
   end

   // Unlock sequencer: arm, wait for last key byte or timeout, check
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ul_ff <= fwuc_pkg::UL_IDLE;
      end else begin
         case (ul_ff)
            fwuc_pkg::UL_IDLE: begin
               if (ctrl_ff.mode_chg && mode_wen) begin
                  ul_ff <= fwuc_pkg::UL_ARMED;
               end
            end
            fwuc_pkg::UL_ARMED: begin
               if (win_over) begin
                  ul_ff <= fwuc_pkg::UL_IDLE;
               end else if (wr_fdh3) begin
                  ul_ff <= fwuc_pkg::UL_CHECK;
               end
            end
            default: begin
               ul_ff <= fwuc_pkg::UL_IDLE;
            end
         endcase
      end
   end

   // Window prescaler and counter run only while armed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_ff <= 7'h00;
         win_ff <= 16'h0000;
      end else if (!armed) begin
         pre_ff <= 7'h00;
         win_ff <= 16'h0000;
      end else begin
         pre_ff <= tick ? 7'h00 : pre_ff + 7'h01;
         if (tick) win_ff <= win_ff + 16'h0001;
      end
   end

   // Write enable: only a good key sets it; clearing the bit relocks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wen_ff <= 1'b0;
      end else if (ul_ff == fwuc_pkg::UL_CHECK && key_ok) begin
         wen_ff <= 1'b1;
      end else if (wr_ctrl && !wd[7]) begin
         wen_ff <= 1'b0;
      end
   end

   // Buffer memory
   fwuc_wbuf fwuc_wbuf_inst (
      .clk(hclk),
      .we(wb_we),
      .waddr(wb_waddr),
      .wdata(wb_wdata),
      .re(do_read),
      .raddr(far_a),
      .rdata(wb_rdata)
   );

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pck_sync_ff <= 2'b00;
         pda_sync_ff <= 2'b00;
         pck_old_ff <= 1'b0;
      end else begin
         pck_sync_ff <= {pck_sync_ff[0], programming_clock_pin};
         pda_sync_ff <= {pda_sync_ff[0], programming_data_pin_i};
         pck_old_ff <= pck_sync_ff[1];
      end
   end

   wire pck_rise = pck_sync_ff[1] && !pck_old_ff;
   wire pck_fall = !pck_sync_ff[1] && pck_old_ff;
   wire word_end = pck_rise && (pbit_ff == 4'hF);

   // Serial shift: sample on rising clock, drive on falling clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pbit_ff <= 4'h0;
         prx_ff <= 16'h0000;
         ptx_ff <= 16'h0000;
         prx_valid_ff <= 1'b0;
         ser_rx_word <= 16'h0000;
      end else begin
         prx_valid_ff <= word_end;
         if (pck_rise) begin
            prx_ff <= {prx_ff[14:0], pda_sync_ff[1]};
            pbit_ff <= pbit_ff + 4'h1;
         end
         if (word_end) begin
            ser_rx_word <= {prx_ff[14:0], pda_sync_ff[1]};
            ptx_ff <= ser_tx_word;
         end else if (pck_fall && pbit_ff != 4'h0) begin
            ptx_ff <= {ptx_ff[14:0], 1'b0};
         end
      end
   end

   // Data pin shares one wire for both directions
   assign programming_data_pin_o = ptx_ff[15];
   assign programming_data_pin_oe = ser_drive;
   assign ser_rx_valid = prx_valid_ff;
endmodule

// File: fwuc_top_props.sv
// Property checker for the flash write unlock control block
`timescale 1ns/1ns
module fwuc_top_props #(
   parameter int UNLOCK_TICKS = 4
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Status and pins
   input wire logic flash_write_enable,
   input wire logic unlock_busy,
   input wire logic ser_drive,
   input wire logic programming_data_pin_oe
);
   // Slack of three cycles over the armed length; cnt_ff counts only cycles with unlock_busy high
   localparam int WIN = UNLOCK_TICKS * 125 + 3;
   logic wr_ctl_ff;
   logic rd_rc_ff;
   logic [19:0] cnt_ff;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Address phase decode, remembered for the data phase
   wire take = hsel & htrans[1] & hready;
   wire nxt_wr_ctl = take & hwrite & (haddr == 32'h0000_0104);
   wire nxt_rd_rc = take & ~hwrite & (haddr == 32'h0000_0100);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ctl_ff <= 1'b0;
         rd_rc_ff <= 1'b0;
         cnt_ff <= 20'h0_0000;
      end else begin
         wr_ctl_ff <= nxt_wr_ctl;
         rd_rc_ff <= nxt_rd_rc;
         cnt_ff <= unlock_busy ? cnt_ff + 20'h0_0001 : 20'h0_0000;
      end
   end
   property p_rc_zero;
      rd_rc_ff |-> hrdata[7:5] == 3'h0 && hrdata[3:1] == 3'h0;
   endproperty
   a_rc_zero: assert property (p_rc_zero)
      else $error("unused clear register bits read nonzero");
   property p_arm;
      wr_ctl_ff && hwdata[6:3] == 4'hD && !unlock_busy |-> ##[1:2] unlock_busy;
   endproperty
   a_arm: assert property (p_arm)
      else $error("unlock window did not open");
   property p_no_arm;
      wr_ctl_ff && hwdata[3] && hwdata[6:4] != 3'h6 && !unlock_busy
         |-> (!unlock_busy) [*3];
   endproperty
   a_no_arm: assert property (p_no_arm)
      else $error("window opened outside enable control mode");
   property p_window;
      cnt_ff <= WIN;
   endproperty
   a_window: assert property (p_window)
      else $error("unlock window outlived its length");
   property p_rise;
      $rose(flash_write_enable) |-> $past(unlock_busy) || $past(unlock_busy, 2);
   endproperty
   a_rise: assert property (p_rise)
      else $error("write enable set without an unlock window");
   property p_clear;
      wr_ctl_ff && !hwdata[7] |=> !flash_write_enable;
   endproperty
   a_clear: assert property (p_clear)
      else $error("write enable survived a clear");
   property p_set_noeff;
      wr_ctl_ff && hwdata[7] && !flash_write_enable && !unlock_busy
         |=> !flash_write_enable;
   endproperty
   a_set_noeff: assert property (p_set_noeff)
      else $error("writing one set write enable");
   property p_fell;
      $fell(flash_write_enable) |-> $past(wr_ctl_ff);
   endproperty
   a_fell: assert property (p_fell)
      else $error("write enable dropped without a control write");
   property p_oe;
      programming_data_pin_oe == ser_drive;
   endproperty
   a_oe: assert property (p_oe)
      else $error("data pin enable does not follow drive request");
   property p_okay;
      hreadyout && !hresp;
   endproperty
   a_okay: assert property (p_okay)
      else $error("bus slave stalled or answered with error");
endmodule
bind fwuc_top fwuc_top_props #(.UNLOCK_TICKS(UNLOCK_TICKS)) fwuc_top_props_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .flash_write_enable(flash_write_enable), .unlock_busy(unlock_busy),
   .ser_drive(ser_drive), .programming_data_pin_oe(programming_data_pin_oe)
);

// File: tb_top.sv
// Self-checking testbench for the flash write unlock control block
`timescale 1ns/1ns
module tb_top;
   // Short unlock window keeps the timeout case quick
   localparam int TICKS = 4;
   // Word the block sends back, and the two words the bench sends in
   localparam logic [15:0] TXW = 16'hA5C3;
   localparam logic [1:0][15:0] SWORD = {16'h5A0F, 16'h3C96};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready, hreadyout, hresp, fwe, busy, pdo, poe, rxv;
   logic [31:0] hrdata, rd;
   logic pclk = 1'b0;
   logic pdi = 1'b0;
   logic ser_drive = 1'b0;
   logic [15:0] rxw, rx_seen = 16'h0000;
   int err_count = 0;
   int n_checks = 0;
   // Key byte addresses, data one low/high to three low/high
   logic [31:0] ka [6] = '{32'h110, 32'h130, 32'h114, 32'h134, 32'h118,
      32'h138};
   logic [7:0] kv [6] = '{fwuc_pkg::KEY_B0, fwuc_pkg::KEY_B1,
      fwuc_pkg::KEY_B2, fwuc_pkg::KEY_B3, fwuc_pkg::KEY_B4, fwuc_pkg::KEY_B5};

   // Clock; the single slave's ready is the bus ready
   always #4 hclk = ~hclk;
   assign hready = hreadyout;

   fwuc_top #(.UNLOCK_TICKS(TICKS)) fwuc_top_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .flash_write_enable(fwe), .unlock_busy(busy),
      .programming_clock_pin(pclk), .programming_data_pin_i(pdi),
      .programming_data_pin_o(pdo), .programming_data_pin_oe(poe),
      .ser_drive(ser_drive), .ser_tx_word(TXW), .ser_rx_word(rxw),
      .ser_rx_valid(rxv)
   );

   // Catch the one-cycle word pulse away from the rising edge
   always @(negedge hclk) begin
      if (rxv === 1'b1) begin
         rx_seen = rxw;
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // One single transfer; values are taken mid-cycle to avoid edge races
   task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d);
      logic ok;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do begin
         @(negedge hclk);
         ok = hready;
         @(posedge hclk);
      end while (ok !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(negedge hclk);
         ok = hready;
         rd = hrdata;
         @(posedge hclk);
      end while (ok !== 1'b1);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Enable and window flags, looked at once settled
   task automatic st(input logic ef, input logic eb);
      @(negedge hclk);
      chk(fwe, ef);
      chk(busy, eb);
      @(posedge hclk);
   endtask

   // Optional arming, then the six key bytes; bad spoils the last one
   task automatic unlock(input logic arm, input logic [7:0] bad);
      if (arm) begin
         wr(32'h104, 32'h0000_0068);
         idle(2);
         st(1'b0, 1'b1);
      end
      for (int i = 0; i < 6; i++) begin
         wr(ka[i], {24'h0, kv[i] ^ ((i == 5) ? bad : 8'h00)});
      end
   endtask

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 1030 cycles
   initial begin
      repeat (6000) @(posedge hclk);
      err_count++;
      wrap_up();
   end

   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(32'h100, 32'h0);
      rdc(32'h104, 32'h0);
      st(1'b0, 1'b0);
      wr(32'h100, 32'h0000_00EE);
      rdc(32'h100, 32'h0);
      wr(32'h100, 32'h0000_0001);
      rdc(32'h100, 32'h1);
      idle(40);
      rdc(32'h100, 32'h0);
      // Mode change in every mode but enable control must not arm
      for (int m = 0; m < 8; m++) begin
         if (m != 6) begin
            wr(32'h104, {24'h0, 1'b0, m[2:0], 4'h8});
            idle(3);
            st(1'b0, 1'b0);
            rdc(32'h104, {24'h0, 1'b0, m[2:0], 4'h0});
         end
      end
      unlock(1'b1, 8'h01);
      idle(3);
      st(1'b0, 1'b0);
      rdc(32'h104, 32'h60);
      wr(32'h104, 32'h0000_0068);
      idle(TICKS * 125 + 10);
      st(1'b0, 1'b0);
      rdc(32'h104, 32'h60);
      unlock(1'b0, 8'h00);
      idle(3);
      st(1'b0, 1'b0);
      unlock(1'b1, 8'h00);
      idle(3);
      st(1'b1, 1'b0);
      rdc(32'h104, 32'hE0);
      // Buffer write then read back while enabled
      wr(32'h10C, 32'h34);
      wr(32'h12C, 32'h12);
      wr(32'h108, 32'h05);
      wr(32'h104, 32'h84);
      idle(3);
      wr(32'h10C, 32'h00);
      wr(32'h12C, 32'h00);
      wr(32'h104, 32'hB3);
      idle(4);
      rdc(32'h10C, 32'h34);
      rdc(32'h12C, 32'h12);
      st(1'b1, 1'b0);
      // Relock, then a write attempt must leave the buffer alone
      wr(32'h104, 32'h00);
      idle(2);
      st(1'b0, 1'b0);
      rdc(32'h104, 32'h0);
      wr(32'h10C, 32'h55);
      wr(32'h104, 32'h84);
      idle(3);
      wr(32'h104, 32'hB3);
      idle(4);
      rdc(32'h10C, 32'h34);
      // Unmapped place reads zero and ignores writes
      wr(32'h200, 32'hFF);
      rdc(32'h200, 32'h0);
      // Two serial words in, msb first; the second shifts out the reply
      ser_drive <= 1'b1;
      @(negedge hclk);
      chk(poe, 32'h1);
      @(posedge hclk);
      for (int w = 0; w < 2; w++) begin
         for (int i = 15; i >= 0; i--) begin
            pdi <= SWORD[w][i];
            idle(4);
            // Data pin settled several cycles after the falling clock
            if (w == 1) chk(pdo, TXW[i]);
            pclk <= 1'b1;
            idle(4);
            pclk <= 1'b0;
         end
         idle(10);
         chk(rx_seen, SWORD[w]);
      end
      wrap_up();
   end
endmodule
